//--- logic/nnmd_decoder.sv
// Power-up node number and fieldbus mode decoder with APB setup registers
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`include "nnmd_consts.svh"

module nnmd_decoder #(
  parameter int SETTLE_CYC = `NNMD_SETTLE_CYC,
  parameter int BLINK_CYC = `NNMD_BLINK_CYC
) (
  // Clock, reset, clock enable
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  // Variant strap, identity pin samples in mV, switch
  input wire logic ECAT_VARIANT,
  input wire logic [11:0] IDENTITY_PIN_LOW_MV,
  input wire logic [11:0] IDENTITY_PIN_MID_MV,
  input wire logic [11:0] IDENTITY_PIN_HIGH_MV,
  input wire logic [5:0] NUMBER_SELECT_SWITCH,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Decoded configuration
  output logic [7:0] NODE_NUMBER,
  output logic PROPRIETARY_CAN_MODE,
  output logic LSS_INACTIVE,
  output logic GREEN_LED,
  output logic [15:0] STATION_ALIAS,
  output logic CONFIG_DONE
);

  // Voltage window to code
  function automatic logic [2:0] nnmd_quantize(input logic [11:0] mv);
    logic [2:0] code;
    code = 3'h7;
    if (mv < `NNMD_WIN0_MV) code = 3'h0;
    else if (mv < `NNMD_WIN1_MV) code = 3'h1;
    else if (mv < `NNMD_WIN2_MV) code = 3'h2;
    else if (mv < `NNMD_WIN3_MV) code = 3'h3;
    else if (mv < `NNMD_WIN4_MV) code = 3'h4;
    else if (mv < `NNMD_WIN5_MV) code = 3'h5;
    else if (mv < `NNMD_WIN6_MV) code = 3'h6;
    return code;
  endfunction

  // Register index of an APB address, 3'h7 when unmapped
  function automatic logic [2:0] nnmd_reg_sel(input logic [11:0] addr);
    logic [2:0] sel;
    sel = 3'h7;
    unique case (addr)
      `NNMD_OFF_CTRL: sel = 3'h0;
      `NNMD_OFF_STATUS: sel = 3'h1;
      `NNMD_OFF_ALIAS: sel = 3'h2;
      `NNMD_OFF_RAW: sel = 3'h3;
      default: sel = 3'h7;
    endcase
    return sel;
  endfunction

  nnmd_pkg::nnmd_state_t state_r;
  nnmd_pkg::nnmd_state_t state_nxt;
  nnmd_pkg::nnmd_ctrl_t ctrl_r;
  nnmd_pkg::nnmd_ctrl_t cfg_r;
  nnmd_pkg::nnmd_codes_t codes_r;
  nnmd_pkg::nnmd_codes_t codes_w;
  nnmd_pkg::nnmd_result_t result_nxt;
  logic [42:0] pin_meta_r;
  logic [42:0] pin_sync_r;
  logic [2:0] over_w;
  logic over_r;
  logic [5:0] sw_r;
  logic variant_r;
  logic [31:0] settle_cnt_r;
  logic [31:0] blink_cnt_r;
  logic [8:0] assembled_w;
  logic all_gnd_w;
  logic use_hw_w;
  logic [7:0] hw_node_w;
  logic hw_src_r;
  logic [2:0] sel_w;
  logic wr_w;
  logic rd_w;

  // Two-flop synchroniser for all pin inputs
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else if (CLK_EN) begin
      pin_meta_r <= {ECAT_VARIANT, NUMBER_SELECT_SWITCH, IDENTITY_PIN_HIGH_MV,
                     IDENTITY_PIN_MID_MV, IDENTITY_PIN_LOW_MV};
      pin_sync_r <= pin_meta_r;
    end
  end

  // Quantize each synchronised pin level
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      assign codes_w[gi*3 +: 3] = nnmd_quantize(pin_sync_r[gi*12 +: 12]);
      assign over_w[gi] = pin_sync_r[gi*12 +: 12] > `NNMD_WIN7_MV;
    end
  endgenerate

  // Sequence: settle, sample once, decode, hold
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      nnmd_pkg::ST_SETTLE: begin
        if (settle_cnt_r == 32'(SETTLE_CYC - 1)) state_nxt = nnmd_pkg::ST_SAMPLE;
      end
      nnmd_pkg::ST_SAMPLE: state_nxt = nnmd_pkg::ST_DECODE;
      nnmd_pkg::ST_DECODE: state_nxt = nnmd_pkg::ST_DONE;
      nnmd_pkg::ST_DONE: state_nxt = nnmd_pkg::ST_DONE;
    endcase
  end

  // State register
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) state_r <= nnmd_pkg::ST_SETTLE;
    else if (CLK_EN) state_r <= state_nxt;
  end

  // Settle counter before the single sample
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) settle_cnt_r <= '0;
    else if (CLK_EN && state_r == nnmd_pkg::ST_SETTLE) settle_cnt_r <= settle_cnt_r + 32'h1;
  end

  // One-time capture of pins and setup word
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      codes_r <= '0;
      sw_r <= '0;
      variant_r <= 1'b0;
      over_r <= 1'b0;
      cfg_r <= `NNMD_CTRL_RESET;
    end else if (CLK_EN && state_r == nnmd_pkg::ST_SAMPLE) begin
      codes_r <= codes_w;
      sw_r <= pin_sync_r[41:36];
      variant_r <= pin_sync_r[42];
      over_r <= |over_w;
      cfg_r <= ctrl_r;
    end
  end

  // Node assembly; bit 8 dropped, bit 7 is the mode
  assign assembled_w = {1'b0, codes_r.high[1:0], codes_r.mid, codes_r.low};
  assign all_gnd_w = codes_r == '0;
  // Hardware path on selection, invalid setup or a stored value of zero
  assign use_hw_w = cfg_r.hw_select || !cfg_r.setup_valid
                    || cfg_r.stored_node == `NNMD_NODE_NONE;

  // Hardware node per variant
  always_comb begin
    if (variant_r) hw_node_w = {2'h0, sw_r};
    else if (all_gnd_w) hw_node_w = `NNMD_NODE_LSS;
    else hw_node_w = {1'b0, assembled_w[6:0]};
  end

  // Result of the decode
  always_comb begin
    result_nxt.hw_source = use_hw_w;
    result_nxt.node = use_hw_w ? hw_node_w : cfg_r.stored_node;
    result_nxt.prop_mode = !variant_r && assembled_w[7];
    result_nxt.lss_inactive = !variant_r && !result_nxt.prop_mode
                              && result_nxt.node == `NNMD_NODE_LSS;
    if (variant_r && cfg_r.node_addr_mode && result_nxt.node != `NNMD_NODE_LSS)
      result_nxt.station_alias = {8'h00, result_nxt.node};
    else
      result_nxt.station_alias = 16'h0000;
  end

  // Decoded outputs latched once and held
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      NODE_NUMBER <= '0;
      PROPRIETARY_CAN_MODE <= 1'b0;
      LSS_INACTIVE <= 1'b0;
      STATION_ALIAS <= '0;
      hw_src_r <= 1'b0;
      CONFIG_DONE <= 1'b0;
    end else if (CLK_EN && state_r == nnmd_pkg::ST_DECODE) begin
      NODE_NUMBER <= result_nxt.node;
      PROPRIETARY_CAN_MODE <= result_nxt.prop_mode;
      LSS_INACTIVE <= result_nxt.lss_inactive;
      STATION_ALIAS <= result_nxt.station_alias;
      hw_src_r <= result_nxt.hw_source;
      CONFIG_DONE <= 1'b1;
    end
  end

  // Green indicator flash while LSS inactive
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      blink_cnt_r <= '0;
      GREEN_LED <= 1'b0;
    end else if (CLK_EN && LSS_INACTIVE) begin
      if (blink_cnt_r == 32'(BLINK_CYC - 1)) begin
        blink_cnt_r <= '0;
        GREEN_LED <= !GREEN_LED;
      end else begin
        blink_cnt_r <= blink_cnt_r + 32'h1;
      end
    end
  end

  // APB decode; answer in the first access cycle
  assign sel_w = nnmd_reg_sel(PADDR);
  assign wr_w = PSEL && PENABLE && PREADY && PWRITE;
  assign rd_w = PSEL && !PENABLE && !PWRITE;

  // Ready and error raised for the access cycle only
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (CLK_EN) begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && sel_w == 3'h7;
    end
  end

  // Setup word; frozen once sampled
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) ctrl_r <= `NNMD_CTRL_RESET;
    else if (CLK_EN && wr_w && sel_w == 3'h0 && state_r == nnmd_pkg::ST_SETTLE)
      ctrl_r <= PWDATA[`NNMD_CTRL_WIDTH-1:0];
  end

  // Read data captured in the setup cycle
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA <= '0;
    end else if (CLK_EN) begin
      PRDATA <= '0;
      if (rd_w) begin
        unique case (sel_w)
          3'h0: PRDATA[`NNMD_CTRL_WIDTH-1:0] <= ctrl_r;
          3'h1: begin
            PRDATA[7:0] <= NODE_NUMBER;
            PRDATA[`NNMD_STAT_PROP_BIT] <= PROPRIETARY_CAN_MODE;
            PRDATA[`NNMD_STAT_LSS_BIT] <= LSS_INACTIVE;
            PRDATA[`NNMD_STAT_DONE_BIT] <= CONFIG_DONE;
            PRDATA[`NNMD_STAT_HWSRC_BIT] <= hw_src_r;
            PRDATA[`NNMD_STAT_ECAT_BIT] <= variant_r;
            PRDATA[`NNMD_STAT_OVER_BIT] <= over_r;
          end
          3'h2: PRDATA[15:0] <= STATION_ALIAS;
          3'h3: PRDATA[14:0] <= {sw_r, codes_r};
          default: PRDATA <= '0;
        endcase
      end
    end
  end

  // Checks on the decoded configuration
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  chk_node_held: assert property (
    (CONFIG_DONE && CLK_EN) |=> ($stable(NODE_NUMBER) && $stable(STATION_ALIAS)))
    else $error("node number changed after decode");

  chk_sample_once: assert property (
    (state_r == nnmd_pkg::ST_SAMPLE && CLK_EN) |=> ##1 (CLK_EN ? CONFIG_DONE : 1'b1))
    else $error("decode did not follow the sample");

  chk_can_assembly: assert property (
    (state_r == nnmd_pkg::ST_DECODE && CLK_EN && use_hw_w && !variant_r && !all_gnd_w)
    |=> NODE_NUMBER == {1'b0, $past(codes_r.high[0]), $past(codes_r.mid), $past(codes_r.low)})
    else $error("CAN node number assembled wrongly");

  chk_mode_bit: assert property (
    (state_r == nnmd_pkg::ST_DECODE && CLK_EN)
    |=> PROPRIETARY_CAN_MODE == (!$past(variant_r) && $past(codes_r.high[1])))
    else $error("mode does not follow bit 7");

  chk_all_ground: assert property (
    (state_r == nnmd_pkg::ST_DECODE && CLK_EN && use_hw_w && !variant_r && all_gnd_w)
    |=> NODE_NUMBER == `NNMD_NODE_LSS)
    else $error("grounded pins did not give 255");

  chk_switch_node: assert property (
    (state_r == nnmd_pkg::ST_DECODE && CLK_EN && use_hw_w && variant_r)
    |=> NODE_NUMBER == {2'h0, $past(sw_r)})
    else $error("switch node number wrong");

  chk_stored_node: assert property (
    (state_r == nnmd_pkg::ST_DECODE && CLK_EN && !use_hw_w)
    |=> NODE_NUMBER == $past(cfg_r.stored_node))
    else $error("stored node number not used");

  chk_fallback: assert property (
    (state_r == nnmd_pkg::ST_DECODE && CLK_EN && !cfg_r.setup_valid) |=> hw_src_r)
    else $error("invalid setup did not use hardware");

  chk_lss_state: assert property (
    (CONFIG_DONE && !variant_r && !PROPRIETARY_CAN_MODE && NODE_NUMBER == `NNMD_NODE_LSS)
    |-> LSS_INACTIVE)
    else $error("LSS inactive state not entered");

  chk_led_idle: assert property (
    !LSS_INACTIVE |-> !GREEN_LED)
    else $error("indicator flashing outside LSS inactive");

  chk_alias_load: assert property (
    (CONFIG_DONE && variant_r && cfg_r.node_addr_mode && NODE_NUMBER != `NNMD_NODE_LSS)
    |-> STATION_ALIAS == {8'h00, NODE_NUMBER})
    else $error("station alias not loaded with node");

  chk_alias_zero: assert property (
    (CONFIG_DONE && NODE_NUMBER == `NNMD_NODE_LSS) |-> STATION_ALIAS == 16'h0000)
    else $error("station alias not zero for 255");

  chk_cfg_frozen: assert property (
    (state_r == nnmd_pkg::ST_DONE && CLK_EN)
    |=> ($stable(codes_r) && $stable(sw_r) && $stable(cfg_r)))
    else $error("sampled inputs changed after the single sample");

  chk_ecat_no_lss: assert property (
    (CONFIG_DONE && variant_r) |-> (!LSS_INACTIVE && !PROPRIETARY_CAN_MODE))
    else $error("switch variant entered a CAN only state");

endmodule

//--- logic/nnmd_consts.svh
// Register offsets, field positions, reset values and timing counts of the node decoder
`ifndef NNMD_CONSTS_SVH
`define NNMD_CONSTS_SVH
// Register byte offsets
`define NNMD_OFF_CTRL 12'h000
`define NNMD_OFF_STATUS 12'h004
`define NNMD_OFF_ALIAS 12'h008
`define NNMD_OFF_RAW 12'h00C
// Control register field positions
`define NNMD_CTRL_NODE_LSB 0
`define NNMD_CTRL_HWSEL_BIT 8
`define NNMD_CTRL_VALID_BIT 9
`define NNMD_CTRL_NAMODE_BIT 10
`define NNMD_CTRL_WIDTH 11
`define NNMD_CTRL_RESET 11'h000
// Status register field positions
`define NNMD_STAT_PROP_BIT 8
`define NNMD_STAT_LSS_BIT 9
`define NNMD_STAT_DONE_BIT 10
`define NNMD_STAT_HWSRC_BIT 11
`define NNMD_STAT_ECAT_BIT 12
`define NNMD_STAT_OVER_BIT 13
// Special node numbers
`define NNMD_NODE_LSS 8'hFF
`define NNMD_NODE_NONE 8'h00
// Upper edges of the identity voltage windows, millivolts
`define NNMD_WIN0_MV 12'h212
`define NNMD_WIN1_MV 12'h582
`define NNMD_WIN2_MV 12'h7DA
`define NNMD_WIN3_MV 12'h97E
`define NNMD_WIN4_MV 12'hABE
`define NNMD_WIN5_MV 12'hBC2
`define NNMD_WIN6_MV 12'hC94
`define NNMD_WIN7_MV 12'hD16
// Timing: clock period, input settle time, LED half period (ns)
`define NNMD_CLK_NS 25
`define NNMD_SETTLE_NS 1000000
`define NNMD_BLINK_HALF_NS 500000000
`define NNMD_SETTLE_CYC ((`NNMD_SETTLE_NS + `NNMD_CLK_NS - 1) / `NNMD_CLK_NS)
`define NNMD_BLINK_CYC (`NNMD_BLINK_HALF_NS / `NNMD_CLK_NS)
`endif

//--- logic/nnmd_pkg.sv
// Types shared by the node number and mode decoder
package nnmd_pkg;
  // Power-up sequence, Gray coded
  typedef enum logic [1:0] {
    ST_SETTLE = 2'h0,
    ST_SAMPLE = 2'h1,
    ST_DECODE = 2'h3,
    ST_DONE = 2'h2
  } nnmd_state_t;
  // Software setup word
  typedef struct packed {
    logic node_addr_mode;
    logic setup_valid;
    logic hw_select;
    logic [7:0] stored_node;
  } nnmd_ctrl_t;
  // Quantized identity pin codes
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] mid;
    logic [2:0] low;
  } nnmd_codes_t;
  // Decoded result
  typedef struct packed {
    logic [15:0] station_alias;
    logic lss_inactive;
    logic prop_mode;
    logic hw_source;
    logic [7:0] node;
  } nnmd_result_t;
endpackage

//--- testbench/nnmd_id_source.sv
// Identity pin dividers and number switch in front of the decoder
`timescale 1ns/1ps
module nnmd_id_source (
  // Chosen pin codes and switch positions
  input wire logic [2:0] code_low,
  input wire logic [2:0] code_mid,
  input wire logic [2:0] code_high,
  input wire logic [5:0] sw_on,
  input wire logic over_high,
  // Pin levels in millivolts and switch lines
  output logic [11:0] mv_low,
  output logic [11:0] mv_mid,
  output logic [11:0] mv_high,
  output logic [5:0] sw_out
);
  // Nominal divider voltage for a code, inside its window
  function automatic logic [11:0] nominal(input logic [2:0] c);
    case (c)
      3'h0: return 12'h000;
      3'h1: return 12'h421;
      3'h2: return 12'h6DC;
      3'h3: return 12'h8CE;
      3'h4: return 12'hA28;
      3'h5: return 12'hB4E;
      3'h6: return 12'hC38;
      default: return 12'hCF7;
    endcase
  endfunction
  // Static levels, ON position pulls its line to one
  assign mv_low = nominal(code_low);
  assign mv_mid = nominal(code_mid);
  // High pin can be overdriven above the top window
  assign mv_high = over_high ? 12'hE10 : nominal(code_high);
  assign sw_out = sw_on;
endmodule

//--- testbench/nnmd_decoder_tb_top.sv
// Self-checking bench for the node number and mode decoder
`timescale 1ns/1ps
module nnmd_decoder_tb_top;
  logic ref_clk, rst_b, ecat, psel, penable, pwrite, pready, pslverr;
  logic prop, lss, led, done, err, led0, clk_en, over_h;
  logic [11:0] paddr, mv_l, mv_m, mv_h;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] c_l, c_m, c_h;
  logic [5:0] sw, sw_pin;
  logic [7:0] node;
  logic [15:0] st_alias;
  int error_cnt, total_checks;

  // Device under test with short settle and blink counts
  nnmd_decoder #(.SETTLE_CYC(4), .BLINK_CYC(8)) nnmd_decoder_inst (
    .REF_CLK(ref_clk), .RST_B(rst_b), .CLK_EN(clk_en), .ECAT_VARIANT(ecat),
    .IDENTITY_PIN_LOW_MV(mv_l), .IDENTITY_PIN_MID_MV(mv_m),
    .IDENTITY_PIN_HIGH_MV(mv_h), .NUMBER_SELECT_SWITCH(sw_pin),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .NODE_NUMBER(node), .PROPRIETARY_CAN_MODE(prop), .LSS_INACTIVE(lss),
    .GREEN_LED(led), .STATION_ALIAS(st_alias), .CONFIG_DONE(done)
  );

  // Pin dividers and switch
  nnmd_id_source nnmd_id_source_inst (
    .code_low(c_l), .code_mid(c_m), .code_high(c_h), .sw_on(sw), .over_high(over_h),
    .mv_low(mv_l), .mv_mid(mv_m), .mv_high(mv_h), .sw_out(sw_pin)
  );

  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Compare and count
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Report and stop
  task automatic complete_run();
    $display("mismatches %0d checks %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reset with given straps, write the setup word, wait for decode
  task automatic power_up(input logic e, input logic [8:0] codes, input logic [5:0] s,
                          input logic [10:0] ctrl);
    int n;
    @(posedge ref_clk);
    rst_b <= 1'b0;
    ecat <= e;
    {c_h, c_m, c_l} <= codes;
    sw <= s;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    apb(1'b1, 12'h000, {21'h0, ctrl});
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    if (done !== 1'b1) begin
      error_cnt++;
      complete_run();
    end
  endtask

  // Decoded outputs against expectation
  task automatic expect_out(input logic [7:0] n, input logic p, input logic l,
                            input logic [15:0] a);
    chk("node", {24'h0, node}, {24'h0, n});
    chk("mode", {31'h0, prop}, {31'h0, p});
    chk("lss", {31'h0, lss}, {31'h0, l});
    chk("alias", {16'h0, st_alias}, {16'h0, a});
  endtask

  // Scenario sequence
  initial begin
    rst_b = 1'b0;
    ecat = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {c_h, c_m, c_l} = 9'h000;
    sw = 6'h00;
    clk_en = 1'b1;
    over_h = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    // Every voltage window on the low pin
    for (int k = 0; k < 8; k++) begin
      power_up(1'b0, {3'h1, 3'h0, k[2:0]}, 6'h00, 11'h000);
      expect_out(8'h40 + 8'(k), 1'b0, 1'b0, 16'h0000);
    end
    power_up(1'b0, {3'h3, 3'h5, 3'h2}, 6'h00, 11'h000);
    expect_out(8'h6A, 1'b1, 1'b0, 16'h0000);
    power_up(1'b0, 9'h1FF, 6'h00, 11'h000);
    expect_out(8'h7F, 1'b1, 1'b0, 16'h0000);
    // High pin above the top window reads as code 7
    over_h <= 1'b1;
    power_up(1'b0, {3'h3, 3'h5, 3'h2}, 6'h00, 11'h000);
    expect_out(8'h6A, 1'b1, 1'b0, 16'h0000);
    apb(1'b0, 12'h00C, 32'h0);
    chk("raw codes", rd, 32'h0000_01EA);
    chk("no error", {31'h0, err}, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk("over status", rd, 32'h0000_2D6A);
    over_h <= 1'b0;
    // All pins grounded: inactive state with blinking LED
    power_up(1'b0, 9'h000, 6'h00, 11'h000);
    expect_out(8'hFF, 1'b0, 1'b1, 16'h0000);
    led0 = led;
    repeat (8) @(posedge ref_clk);
    chk("led", {31'h0, led}, {31'h0, ~led0});
    // Late pin change and late setup write are ignored
    c_l <= 3'h5;
    apb(1'b1, 12'h000, 32'h0000_022A);
    repeat (6) @(posedge ref_clk);
    expect_out(8'hFF, 1'b0, 1'b1, 16'h0000);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl", rd, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", rd, 32'h0000_0EFF);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    // Clock enable low holds the power-up sequence
    @(posedge ref_clk);
    rst_b <= 1'b0;
    clk_en <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (12) @(posedge ref_clk);
    chk("frozen done", {31'h0, done}, 32'h0);
    clk_en <= 1'b1;
    // Stored setting against hardware selection and invalid setup
    power_up(1'b0, {3'h2, 3'h0, 3'h1}, 6'h00, 11'h22A);
    expect_out(8'h2A, 1'b1, 1'b0, 16'h0000);
    power_up(1'b0, {3'h1, 3'h0, 3'h3}, 6'h00, 11'h32A);
    expect_out(8'h43, 1'b0, 1'b0, 16'h0000);
    power_up(1'b0, {3'h1, 3'h0, 3'h3}, 6'h00, 11'h02A);
    expect_out(8'h43, 1'b0, 1'b0, 16'h0000);
    // Switch variant, alias loading and its exceptions
    power_up(1'b1, 9'h000, 6'h2D, 11'h400);
    expect_out(8'h2D, 1'b0, 1'b0, 16'h002D);
    apb(1'b0, 12'h008, 32'h0);
    chk("alias reg", rd, 32'h0000_002D);
    power_up(1'b1, 9'h000, 6'h3F, 11'h000);
    expect_out(8'h3F, 1'b0, 1'b0, 16'h0000);
    power_up(1'b1, 9'h000, 6'h3F, 11'h6FF);
    expect_out(8'hFF, 1'b0, 1'b0, 16'h0000);
    complete_run();
  end
endmodule
